// >>> hdl/adcpc_defines.svh
// Purpose: offsets, field positions, reset values and counts of the converter output stage
// Assumes: byte addressed register bus, one aligned 32-bit word per register
// Notes: definitions only
`ifndef ADCPC_DEFINES_SVH
`define ADCPC_DEFINES_SVH

// --------------------
// register offsets (byte addresses)
// --------------------
`define ADCPC_CTRL_OFS 4'h0
`define ADCPC_STAT_OFS 4'h4
`define ADCPC_PWR_OFS 4'h8

// --------------------
// control word fields
// --------------------
`define ADCPC_CTRL_DIV_LSB 0
`define ADCPC_CTRL_FMT_LSB 2
`define ADCPC_CTRL_CLKINV_BIT 4
`define ADCPC_CTRL_RST 5'h00

// --------------------
// power word fields
// --------------------
`define ADCPC_PWR_MODE_LSB 0
`define ADCPC_PWR_PINFN_LSB 5
`define ADCPC_PWR_RST 7'h00

// --------------------
// divider selections, pin functions and power modes
// --------------------
`define ADCPC_DIV_BY1 2'h0
`define ADCPC_DIV_BY2 2'h1
`define ADCPC_DIV_BY4 2'h2
`define ADCPC_PINFN_PWRDN 2'h0
`define ADCPC_PINFN_OUTEN 2'h1
`define ADCPC_PMODE_NORMAL 2'h0
`define ADCPC_PMODE_DOWN 2'h1
`define ADCPC_PMODE_STBY 2'h2

// --------------------
// data path figures
// --------------------
`define ADCPC_LATENCY 8
`define ADCPC_CODE_W 14
`define ADCPC_MIDCODE 14'h2000
`define ADCPC_FS_POS 16'sh1fff
`define ADCPC_FS_NEG (-16'sh2000)

`endif

// >>> hdl/adcpc_pkg.sv
// Purpose: shared types of the converter output stage
// Assumes: constants come from adcpc_defines.svh
// Notes: nothing here is imported; users write adcpc_pkg::name
`default_nettype none

package adcpc_pkg;
  // one converted word with its over-range flag
  typedef struct packed {
    logic over_range;
    logic [13:0] code;
  } adcpc_sample_t;

  // output coding
  typedef enum logic [1:0] {
    FMT_OFFSET = 2'h0,
    FMT_TWOS = 2'h1,
    FMT_GRAY = 2'h2
  } adcpc_fmt_t;

  // power state, one-hot
  typedef enum logic [2:0] {
    PWR_ON = 3'h1,
    PWR_STBY = 3'h2,
    PWR_DOWN = 3'h4
  } adcpc_pwr_t;
endpackage

`default_nettype wire

// >>> hdl/adcpc_skid.sv
// Purpose: two-entry buffer with valid and ready on both sides
// Assumes: single clock, asynchronous active-low reset
// Notes: in_ready_out is high only while an entry is free, so nothing is dropped
`default_nettype none

module adcpc_skid #(
  parameter int W = 15
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // filling side
  input wire logic in_valid_in,
  input wire logic [W-1:0] in_data_in,
  output logic in_ready_out,
  // draining side
  output logic out_valid_out,
  output logic [W-1:0] out_data_out,
  input wire logic out_ready_in
);
  // --------------------
  // storage
  // --------------------
  logic [W-1:0] mem_ff [2]; // two words
  logic [W-1:0] nxt_mem [2];
  logic rd_ff, nxt_rd; // read pointer
  logic wr_ff, nxt_wr; // write pointer
  logic [1:0] cnt_ff, nxt_cnt; // fill level
  logic push, pop;

  assign in_ready_out = (cnt_ff != 2'h2);
  assign out_valid_out = (cnt_ff != 2'h0);
  assign out_data_out = mem_ff[rd_ff];
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;

  // next pointers and contents
  always_comb begin
    nxt_mem = mem_ff;
    nxt_rd = rd_ff ^ pop;
    nxt_wr = wr_ff ^ push;
    nxt_cnt = cnt_ff;
    if (push) begin
      nxt_mem[wr_ff] = in_data_in;
    end
    if (push & ~pop) begin
      nxt_cnt = cnt_ff + 2'h1;
    end else if (pop & ~push) begin
      nxt_cnt = cnt_ff - 2'h1;
    end
  end

  // registers only
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mem_ff[0] <= '0;
      mem_ff[1] <= '0;
      rd_ff <= 1'b0;
      wr_ff <= 1'b0;
      cnt_ff <= 2'h0;
    end else begin
      mem_ff <= nxt_mem;
      rd_ff <= nxt_rd;
      wr_ff <= nxt_wr;
      cnt_ff <= nxt_cnt;
    end
  end
endmodule

`default_nettype wire

// >>> hdl/adcpc_top.sv
// Purpose: digital control and output stage of a 14-bit sampling converter
// Assumes: all pins synchronous to core_clk_in; sample clock edges seen as a level
// Notes: registers reached over Avalon-MM with waitrequest
// Operation
// R1 - divide sample clock by 1, 2 or 4
// R2 - sample appears eight conversion cycles later
// R3 - pin mode: power-down pin high powers down
// R4 - serial mode: register or mode pin powers down
// R5 - powered down: data drivers high impedance
// R6 - standby keeps reference powered
// R7 - straps choose format and output disable
// R8 - serial mode: offset, twos or gray coding
// R9 - mode pin output-enable only when field set
// R10 - mode pin low drives, high floats outputs
// R11 - data valid at clock rising, polarity selectable
// R12 - offset binary codes, saturation, over-range flag
// R13 - gray code from offset binary by xor
//
// The register offsets and register access over Avalon-MM were left to the implementer.
`include "adcpc_defines.svh"
`default_nettype none

module adcpc_top (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // register bus
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // converter side
  input wire logic sample_clk_in,
  input wire logic signed [15:0] analog_code_in,
  // control pins
  input wire logic serial_port_used_in,
  input wire logic power_down_pin_in,
  input wire logic serial_clock_or_format_pin_in,
  input wire logic serial_data_or_powerdown_pin_in,
  input wire logic output_enable_low_in,
  // output bus
  output logic [13:0] data_out,
  output logic over_range_out,
  output logic data_oe_out,
  output logic data_clock_out,
  output logic data_clock_oe_out,
  input wire logic data_ready_in,
  // power status
  output logic ref_power_out,
  output logic core_power_out
);
  // ----------------------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------------------
  logic ack_ff, nxt_ack; // answer cycle marker
  logic [4:0] ctrl_ff, nxt_ctrl; // divider, format, clock polarity
  logic [6:0] pwr_ff, nxt_pwr; // power mode, mode pin function
  logic [31:0] rdata_ff, nxt_rdata; // read data held for the answer cycle
  logic [7:0] status; // live state word
  logic req;

  assign req = avs_read_in | avs_write_in;
  // first cycle of a request waits, the second answers
  assign avs_waitrequest_out = req & ~ack_ff;
  assign avs_readdata_out = rdata_ff;

  // decode and next register values
  always_comb begin
    nxt_ack = req & ~ack_ff;
    nxt_ctrl = ctrl_ff;
    nxt_pwr = pwr_ff;
    nxt_rdata = rdata_ff;
    if (avs_read_in & ~ack_ff) begin
      case (avs_address_in)
        `ADCPC_CTRL_OFS: nxt_rdata = {27'h0, ctrl_ff};
        `ADCPC_STAT_OFS: nxt_rdata = {24'h0, status};
        `ADCPC_PWR_OFS: nxt_rdata = {25'h0, pwr_ff};
        default: nxt_rdata = 32'h0; // unmapped reads zero
      endcase
    end
    // write takes effect only in the answer cycle
    if (avs_write_in & ack_ff & avs_byteenable_in[0]) begin
      case (avs_address_in)
        `ADCPC_CTRL_OFS: nxt_ctrl = avs_writedata_in[4:0];
        `ADCPC_PWR_OFS: nxt_pwr = avs_writedata_in[6:0];
        default: nxt_ctrl = ctrl_ff; // unmapped and status writes ignored
      endcase
    end
  end

  // bus registers
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ack_ff <= 1'b0;
      ctrl_ff <= `ADCPC_CTRL_RST;
      pwr_ff <= `ADCPC_PWR_RST;
      rdata_ff <= 32'h0;
    end else begin
      ack_ff <= nxt_ack;
      ctrl_ff <= nxt_ctrl;
      pwr_ff <= nxt_pwr;
      rdata_ff <= nxt_rdata;
    end
  end

  // ----------------------------------------------------------------------------
  // strap capture
  // ----------------------------------------------------------------------------
  logic strap_done_ff, nxt_strap_done; // straps taken once after reset
  logic strap_fmt_ff, nxt_strap_fmt; // high selects twos complement
  logic strap_dis_ff, nxt_strap_dis; // high disables outputs

  // straps are caught by the first clock after release, never under reset
  always_comb begin
    nxt_strap_done = 1'b1;
    nxt_strap_fmt = strap_fmt_ff;
    nxt_strap_dis = strap_dis_ff;
    if (!strap_done_ff) begin
      nxt_strap_fmt = serial_clock_or_format_pin_in; // R7
      nxt_strap_dis = serial_data_or_powerdown_pin_in; // R7
    end
  end

  // strap registers
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      strap_done_ff <= 1'b0;
      strap_fmt_ff <= 1'b0;
      strap_dis_ff <= 1'b0;
    end else begin
      strap_done_ff <= nxt_strap_done;
      strap_fmt_ff <= nxt_strap_fmt;
      strap_dis_ff <= nxt_strap_dis;
    end
  end

  // ----------------------------------------------------------------------------
  // power control
  // ----------------------------------------------------------------------------
  adcpc_pkg::adcpc_pwr_t pwr_st_ff, nxt_pwr_st;
  logic [1:0] pmode;
  logic [1:0] pinfn;
  logic want_down;
  logic want_stby;
  logic pin_float;

  assign pmode = pwr_ff[`ADCPC_PWR_MODE_LSB +: 2];
  assign pinfn = pwr_ff[`ADCPC_PWR_PINFN_LSB +: 2];

  // power request from pins or from the serial settings
  always_comb begin
    if (!serial_port_used_in) begin
      want_down = power_down_pin_in; // R3
      want_stby = 1'b0;
    end else begin
      // mode pin low releases only the pin request, not the register one
      want_down = (pmode == `ADCPC_PMODE_DOWN) |
                  ((pinfn == `ADCPC_PINFN_PWRDN) & output_enable_low_in); // R4
      want_stby = (pmode == `ADCPC_PMODE_STBY); // R6
    end
  end

  // power state machine
  always_comb begin
    case (pwr_st_ff)
      adcpc_pkg::PWR_ON,
      adcpc_pkg::PWR_STBY,
      adcpc_pkg::PWR_DOWN: begin
        if (want_down) begin
          nxt_pwr_st = adcpc_pkg::PWR_DOWN; // R3 R4
        end else if (want_stby) begin
          nxt_pwr_st = adcpc_pkg::PWR_STBY; // R6
        end else begin
          nxt_pwr_st = adcpc_pkg::PWR_ON;
        end
      end
      default: nxt_pwr_st = adcpc_pkg::PWR_ON;
    endcase
  end

  // power state register
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pwr_st_ff <= adcpc_pkg::PWR_ON;
    end else begin
      pwr_st_ff <= nxt_pwr_st;
    end
  end

  // standby keeps the reference alive for a quicker wake
  assign ref_power_out = (pwr_st_ff != adcpc_pkg::PWR_DOWN); // R6
  assign core_power_out = (pwr_st_ff == adcpc_pkg::PWR_ON);

  // mode pin floats the bus only when programmed as output enable
  assign pin_float = serial_port_used_in & (pinfn == `ADCPC_PINFN_OUTEN) &
                     output_enable_low_in; // R9 R10
  assign data_oe_out = core_power_out & ~pin_float &
                       ~(~serial_port_used_in & strap_dis_ff); // R5 R7 R10
  assign data_clock_oe_out = data_oe_out; // R10

  // ----------------------------------------------------------------------------
  // clock divider
  // ----------------------------------------------------------------------------
  logic smp_d_ff, nxt_smp_d; // last sample clock level
  logic [1:0] div_cnt_ff, nxt_div_cnt; // edges seen in this period
  logic [1:0] div_last; // last count of the period
  logic tick; // one conversion cycle

  // ratio to last count; the spare selection behaves as divide by four
  always_comb begin
    case (ctrl_ff[`ADCPC_CTRL_DIV_LSB +: 2])
      `ADCPC_DIV_BY1: div_last = 2'h0; // R1
      `ADCPC_DIV_BY2: div_last = 2'h1; // R1
      default: div_last = 2'h3; // R1
    endcase
  end

  assign tick = sample_clk_in & ~smp_d_ff & core_power_out & (div_cnt_ff == div_last);

  // count rising sample clock edges while converting
  always_comb begin
    nxt_smp_d = sample_clk_in;
    nxt_div_cnt = div_cnt_ff;
    if (!core_power_out) begin
      nxt_div_cnt = 2'h0; // restart cleanly on wake
    end else if (sample_clk_in & ~smp_d_ff) begin
      nxt_div_cnt = tick ? 2'h0 : div_cnt_ff + 2'h1; // R1
    end
  end

  // divider registers
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      smp_d_ff <= 1'b0;
      div_cnt_ff <= 2'h0;
    end else begin
      smp_d_ff <= nxt_smp_d;
      div_cnt_ff <= nxt_div_cnt;
    end
  end

  // ----------------------------------------------------------------------------
  // quantiser and coding
  // ----------------------------------------------------------------------------
  adcpc_pkg::adcpc_fmt_t fmt;
  adcpc_pkg::adcpc_sample_t conv; // coded word of this conversion
  logic [13:0] ob; // offset binary result

  // pin mode only knows two codings
  always_comb begin
    if (!serial_port_used_in) begin
      fmt = strap_fmt_ff ? adcpc_pkg::FMT_TWOS : adcpc_pkg::FMT_OFFSET; // R7
    end else begin
      case (ctrl_ff[`ADCPC_CTRL_FMT_LSB +: 2])
        2'h1: fmt = adcpc_pkg::FMT_TWOS; // R8
        2'h2: fmt = adcpc_pkg::FMT_GRAY; // R8
        default: fmt = adcpc_pkg::FMT_OFFSET; // R8
      endcase
    end
  end

  // saturate beyond full scale and flag it
  always_comb begin
    conv.over_range = 1'b0;
    if (analog_code_in > `ADCPC_FS_POS) begin
      ob = 14'h3fff; // R12
      conv.over_range = 1'b1; // R12
    end else if (analog_code_in < `ADCPC_FS_NEG) begin
      ob = 14'h0000; // R12
      conv.over_range = 1'b1; // R12
    end else begin
      ob = analog_code_in[13:0] ^ `ADCPC_MIDCODE; // R12
    end
    case (fmt)
      adcpc_pkg::FMT_TWOS: conv.code = {~ob[13], ob[12:0]}; // R12
      adcpc_pkg::FMT_GRAY: conv.code = ob ^ {1'b0, ob[13:1]}; // R13
      default: conv.code = ob;
    endcase
  end

  // ----------------------------------------------------------------------------
  // pipeline, buffer and output register
  // ----------------------------------------------------------------------------
  localparam int STAGES = `ADCPC_LATENCY - 1;
  adcpc_pkg::adcpc_sample_t pipe_ff [STAGES];
  adcpc_pkg::adcpc_sample_t nxt_pipe [STAGES];
  logic [STAGES-1:0] pv_ff, nxt_pv; // stage holds a real sample
  logic buf_in_ready;
  logic buf_out_valid;
  logic [14:0] buf_out_data;
  logic advance; // pipeline steps this cycle
  logic [13:0] dout_ff, nxt_dout;
  logic or_ff, nxt_or;
  logic dclk_ff, nxt_dclk; // high half of the data clock

  // a full buffer stalls sampling so no word is lost
  assign advance = tick & buf_in_ready;

  // shift one stage per conversion cycle
  always_comb begin
    nxt_pipe = pipe_ff;
    nxt_pv = pv_ff;
    if (advance) begin
      nxt_pipe[0] = conv; // R2
      nxt_pv[0] = 1'b1;
      for (int i = 1; i < STAGES; i++) begin
        nxt_pipe[i] = pipe_ff[i-1]; // R2
        nxt_pv[i] = pv_ff[i-1];
      end
    end
  end

  // pipeline registers
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < STAGES; i++) begin
        pipe_ff[i] <= '0;
      end
      pv_ff <= '0;
    end else begin
      pipe_ff <= nxt_pipe;
      pv_ff <= nxt_pv;
    end
  end

  // holds the oldest words while the receiver stalls
  adcpc_skid #(
    .W(15)
  ) u_buf (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .in_valid_in(advance & pv_ff[STAGES-1]),
    .in_data_in(pipe_ff[STAGES-1]),
    .in_ready_out(buf_in_ready),
    .out_valid_out(buf_out_valid),
    .out_data_out(buf_out_data),
    .out_ready_in(tick & data_ready_in)
  );

  // output word changes on a conversion cycle, clock rises one cycle later
  always_comb begin
    nxt_dout = dout_ff;
    nxt_or = or_ff;
    nxt_dclk = 1'b1; // R11
    if (tick) begin
      nxt_dclk = 1'b0; // R11
      if (buf_out_valid & data_ready_in) begin
        nxt_dout = buf_out_data[13:0]; // R2
        nxt_or = buf_out_data[14]; // R12
      end
    end
  end

  // output registers
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dout_ff <= 14'h0000;
      or_ff <= 1'b0;
      dclk_ff <= 1'b0;
    end else begin
      dout_ff <= nxt_dout;
      or_ff <= nxt_or;
      dclk_ff <= nxt_dclk;
    end
  end

  assign data_out = dout_ff;
  assign over_range_out = or_ff;
  // serial setting may invert the clock so data are valid at its falling edge
  assign data_clock_out = dclk_ff ^ (serial_port_used_in & ctrl_ff[`ADCPC_CTRL_CLKINV_BIT]); // R11

  // status word for software
  assign status = {~buf_in_ready, data_oe_out, strap_dis_ff, strap_fmt_ff,
                   pwr_st_ff, serial_port_used_in};
endmodule

`default_nettype wire

// >>> sim/adcpc_top_chk.sv
// Purpose: port-level checks of the converter output stage
// Assumes: bound to adcpc_top; register fields mirrored from accepted bus writes
// Notes: margins of one cycle cover the registered power state
`include "adcpc_defines.svh"
`default_nettype none

module adcpc_top_chk (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // register bus
  input wire logic [3:0] avs_address_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  input wire logic avs_waitrequest_out,
  // control pins
  input wire logic serial_port_used_in,
  input wire logic power_down_pin_in,
  input wire logic output_enable_low_in,
  // output bus and power
  input wire logic [13:0] data_out,
  input wire logic over_range_out,
  input wire logic data_oe_out,
  input wire logic data_clock_out,
  input wire logic data_clock_oe_out,
  input wire logic ref_power_out,
  input wire logic core_power_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // register mirror
  // ----
  logic inv_ff, nxt_inv; // clock polarity bit
  logic [1:0] fn_ff, nxt_fn, pm_ff, nxt_pm; // mode pin function, power mode
  logic acc, srl_inv, pin_dn, oe_fl;
  assign acc = avs_write_in & ~avs_waitrequest_out & avs_byteenable_in[0];
  assign srl_inv = serial_port_used_in & inv_ff; // polarity counts only in serial mode
  assign pin_dn = serial_port_used_in & (fn_ff == `ADCPC_PINFN_PWRDN) & output_enable_low_in;
  assign oe_fl = serial_port_used_in & (fn_ff == `ADCPC_PINFN_OUTEN) & output_enable_low_in;
  // next mirror values from a write taken at this edge
  always_comb begin
    nxt_inv = inv_ff;
    nxt_fn = fn_ff;
    nxt_pm = pm_ff;
    if (acc && avs_address_in == `ADCPC_CTRL_OFS) begin
      nxt_inv = avs_writedata_in[`ADCPC_CTRL_CLKINV_BIT];
    end
    if (acc && avs_address_in == `ADCPC_PWR_OFS) begin
      nxt_pm = avs_writedata_in[1:0];
      nxt_fn = avs_writedata_in[6:5];
    end
  end
  // mirror registers
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      inv_ff <= 1'b0;
      fn_ff <= 2'h0;
      pm_ff <= 2'h0;
    end else begin
      inv_ff <= nxt_inv;
      fn_ff <= nxt_fn;
      pm_ff <= nxt_pm;
    end
  end

  // ----
  // assertions
  // ----
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  ref_kept_a: assert property (core_power_out |-> ref_power_out)
    else $error("core powered with reference off");
  down_float_a: assert property (!ref_power_out |-> !data_oe_out && !data_clock_oe_out)
    else $error("outputs driven while powered down");
  oe_pair_a: assert property (data_clock_oe_out == data_oe_out)
    else $error("data clock enable differs from data enable");
  pin_down_a: assert property ((!serial_port_used_in && power_down_pin_in)[*2] |->
    !core_power_out && !ref_power_out) else $error("pin power down ignored");
  pin_wake_a: assert property ((!serial_port_used_in && !power_down_pin_in)[*2] |->
    core_power_out) else $error("no wake with power down pin low");
  mode_down_a: assert property ((serial_port_used_in &&
    (pm_ff == `ADCPC_PMODE_DOWN || pin_dn))[*2] |-> !ref_power_out && !core_power_out)
    else $error("serial power down ignored");
  stby_keep_a: assert property ((serial_port_used_in && pm_ff == `ADCPC_PMODE_STBY &&
    !pin_dn)[*2] |-> ref_power_out && !core_power_out) else $error("standby state wrong");
  pin_float_a: assert property (oe_fl[*2] |-> !data_oe_out)
    else $error("outputs driven with mode pin high");
  pin_gate_a: assert property ((serial_port_used_in && !oe_fl && !pin_dn &&
    pm_ff == `ADCPC_PMODE_NORMAL)[*2] |-> data_oe_out) else $error("outputs floated wrongly");
  or_sat_a: assert property (over_range_out |->
    data_out inside {14'h0000, 14'h3fff, 14'h2000, 14'h1fff}) else $error("unsaturated code");
  dclk_edge_a: assert property ($changed(data_out) |-> data_clock_out == srl_inv
    ##1 (data_clock_out != srl_inv || $changed(srl_inv))) else $error("data clock edge wrong");
endmodule

bind adcpc_top adcpc_top_chk u_chk (.core_clk_in, .rst_n_in, .avs_address_in, .avs_write_in,
  .avs_writedata_in, .avs_byteenable_in, .avs_waitrequest_out, .serial_port_used_in,
  .power_down_pin_in, .output_enable_low_in, .data_out, .over_range_out, .data_oe_out,
  .data_clock_out, .data_clock_oe_out, .ref_power_out, .core_power_out);

`default_nettype wire

// >>> sim/adcpc_rx_model.sv
// Purpose: capture register on the far side of the output bus
// Assumes: data clock seen as a level at core_clk_in
// Notes: a released bus reads as the inverse of the last capture
`default_nettype none

module adcpc_rx_model (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // bus pins
  input wire adcpc_pkg::adcpc_sample_t word_in,
  input wire logic oe_in,
  input wire logic dclk_in,
  // receiver settings and results
  input wire logic inv_in,
  input wire logic stall_in,
  output var logic ready_out,
  output var adcpc_pkg::adcpc_sample_t cap_out,
  output var logic [15:0] cnt_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic act_ff, act; // active level of the data clock
  adcpc_pkg::adcpc_sample_t pin;
  assign act = dclk_in ^ inv_in;
  assign pin = oe_in ? word_in : ~cap_out;
  assign ready_out = ~stall_in;
  // latch a word on each active edge while driven and ready
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      act_ff <= 1'b0;
      cap_out <= '0;
      cnt_out <= 16'h0;
    end else begin
      act_ff <= act;
      if (act && !act_ff && oe_in && !stall_in) begin
        cap_out <= pin;
        cnt_out <= cnt_out + 16'h1;
      end
    end
  end
endmodule

`default_nettype wire

// >>> sim/adcpc_top_tb.sv
// Purpose: self-checking bench of the converter output stage
// Assumes: bus waited on by handshake; outputs read from negedge shadows
// Notes: coding cases run from a table, power and pin cases by hand
`include "adcpc_defines.svh"
`default_nettype none

module adcpc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [4:0] ctrl;
    logic [15:0] code;
    logic [14:0] exp;
  } adcpc_row_t;
  // ----
  // stimulus, outputs and shadows
  // ----
  logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, smp = 1'b0, run = 1'b0;
  logic spi = 1'b1, pdn = 1'b0, fmt_s = 1'b0, dis_s = 1'b0, mpin = 1'b0;
  logic stall = 1'b0, inv = 1'b0;
  logic [3:0] addr = 4'h0, be = 4'hf;
  logic [31:0] wdat = 32'h0, rdat, q, rs;
  logic [15:0] code = 16'h0, cnt, s_cnt, c0;
  logic [13:0] dout;
  logic wreq, orng, oe, oe_c, dclk, refp, corep, rdy, ws, s_oe, s_oec, s_ref, s_core, s_smp;
  adcpc_pkg::adcpc_sample_t word, cap, s_cap, s_word;
  int mismatches = 0, num_checks = 0;
  adcpc_row_t rows [12] = '{'{5'h00, 16'h0000, 15'h2000}, '{5'h00, 16'he000, 15'h0000},
    '{5'h00, 16'h1fff, 15'h3fff}, '{5'h00, 16'h2328, 15'h7fff}, '{5'h00, 16'hdcd8, 15'h4000},
    '{5'h04, 16'h0000, 15'h0000}, '{5'h04, 16'h1fff, 15'h1fff}, '{5'h04, 16'hdcd8, 15'h6000},
    '{5'h08, 16'h0005, 15'h3007}, '{5'h08, 16'h1fff, 15'h2000}, '{5'h18, 16'h2328, 15'h6000},
    '{5'h1c, 16'h0005, 15'h2005}};
  assign word = {orng, dout};

  adcpc_top dut (.core_clk_in(clk), .rst_n_in(rst_n), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdat), .avs_byteenable_in(be),
    .avs_readdata_out(rdat), .avs_waitrequest_out(wreq), .sample_clk_in(smp),
    .analog_code_in(code), .serial_port_used_in(spi), .power_down_pin_in(pdn),
    .serial_clock_or_format_pin_in(fmt_s), .serial_data_or_powerdown_pin_in(dis_s),
    .output_enable_low_in(mpin), .data_out(dout), .over_range_out(orng), .data_oe_out(oe),
    .data_clock_out(dclk), .data_clock_oe_out(oe_c), .data_ready_in(rdy),
    .ref_power_out(refp), .core_power_out(corep));
  adcpc_rx_model rx (.core_clk_in(clk), .rst_n_in(rst_n), .word_in(word), .oe_in(oe),
    .dclk_in(dclk), .inv_in(inv), .stall_in(stall), .ready_out(rdy), .cap_out(cap),
    .cnt_out(cnt));

  // clock, sample clock and settled shadows
  always #10 clk = ~clk;
  always @(posedge clk) if (run) smp <= ~smp;
  always @(negedge clk) begin
    ws = wreq;
    rs = rdat;
    s_oe = oe;
    s_oec = oe_c;
    s_ref = refp;
    s_core = corep;
    s_cap = cap;
    s_cnt = cnt;
    s_word = word;
    s_smp = smp;
  end

  // ----
  // tasks
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one bus transfer, entered just after a rising edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    addr <= a;
    wdat <= d;
    wr <= w;
    rd <= ~w;
    do @(posedge clk); while (ws !== 1'b0);
    q = rs;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
  endtask
  task automatic settle();
    repeat (3) @(posedge clk);
  endtask
  task automatic tally_and_finish();
    if (mismatches == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // watchdog well above the expected one thousand or so cycles
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    tally_and_finish();
  end

  // ----
  // main sequence
  // ----
  initial begin
    @(posedge clk);
    do_reset();
    run <= 1'b1;
    bus(1'b0, `ADCPC_CTRL_OFS, 32'h0);
    chk(q, 32'h0);
    bus(1'b0, `ADCPC_PWR_OFS, 32'h0);
    chk(q, 32'h0);
    bus(1'b0, `ADCPC_STAT_OFS, 32'h0);
    chk(q, 32'h43);
    bus(1'b0, 4'hc, 32'h0);
    chk(q, 32'h0);
    be <= 4'he;
    bus(1'b1, `ADCPC_PWR_OFS, 32'h1);
    be <= 4'hf;
    bus(1'b0, `ADCPC_PWR_OFS, 32'h0);
    chk(q, 32'h0);
    // latency from a rising sample edge, divider by one
    repeat (30) @(posedge clk);
    while (s_smp !== 1'b0) @(posedge clk);
    code <= 16'd100;
    repeat (17) @(posedge clk);
    chk(s_word, 15'h2000);
    @(posedge clk);
    chk(s_word, 15'h2064);
    // words per fixed span for each divider ratio
    for (int d = 0; d < 3; d++) begin
      bus(1'b1, `ADCPC_CTRL_OFS, 32'(d));
      repeat (20) @(posedge clk);
      c0 = s_cnt;
      repeat (80) @(posedge clk);
      chk(32'(s_cnt - c0), 32'(40 >> d));
    end
    foreach (rows[i]) begin
      bus(1'b1, `ADCPC_CTRL_OFS, {27'h0, rows[i].ctrl});
      code <= rows[i].code;
      inv <= rows[i].ctrl[4];
      repeat (40) @(posedge clk);
      chk(s_cap, rows[i].exp);
    end
    // receiver stall, then resume with a new value
    bus(1'b1, `ADCPC_CTRL_OFS, 32'h0);
    inv <= 1'b0;
    stall <= 1'b1;
    code <= 16'd7;
    repeat (30) @(posedge clk);
    stall <= 1'b0;
    repeat (40) @(posedge clk);
    chk(s_cap, 15'h2007);
    // mode pin functions and power modes
    bus(1'b1, `ADCPC_PWR_OFS, 32'h20);
    mpin <= 1'b1;
    settle();
    chk({s_oe, s_oec}, 2'b00);
    mpin <= 1'b0;
    settle();
    chk({s_oe, s_oec}, 2'b11);
    bus(1'b1, `ADCPC_PWR_OFS, 32'h40);
    mpin <= 1'b1;
    settle();
    chk(s_oe, 1'b1);
    bus(1'b1, `ADCPC_PWR_OFS, 32'h0);
    settle();
    chk({s_ref, s_core, s_oe}, 3'b000);
    mpin <= 1'b0;
    settle();
    chk(s_core, 1'b1);
    bus(1'b1, `ADCPC_PWR_OFS, 32'h2);
    settle();
    chk({s_ref, s_core}, 2'b10);
    bus(1'b1, `ADCPC_PWR_OFS, 32'h1);
    settle();
    chk({s_ref, s_core, s_oe}, 3'b000);
    bus(1'b1, `ADCPC_PWR_OFS, 32'h0);
    // pin mode with straps taken after reset
    spi <= 1'b0;
    fmt_s <= 1'b1;
    do_reset();
    repeat (40) @(posedge clk);
    chk(s_cap, 15'h0007);
    pdn <= 1'b1;
    settle();
    chk({s_ref, s_core, s_oe}, 3'b000);
    pdn <= 1'b0;
    settle();
    chk(s_core, 1'b1);
    dis_s <= 1'b1;
    do_reset();
    settle();
    chk(s_oe, 1'b0);
    tally_and_finish();
  end
endmodule

`default_nettype wire
